// *** logic/fgr_refresh_mode.sv ***
// refresh rate mode logic: mode field, granularity pick per refresh,
// interval and cycle-time tracking, and checks on the controller
// assumes the command pins are sampled on clk like the rest of the
// command bus, so they are same-domain and not resynchronised
`timescale 1ns/1ps
module fgr_refresh_mode #(
   parameter int DENSITY = 1,   // 0..3 for 2, 4, 8, 16 Gb
   parameter int ADDR_W = 18    // address pins carried
) (
   input wire logic clk,                  // command clock
   input wire logic srst,                 // sync reset, active high
   input wire logic csN,                  // chip select, low active
   input wire logic actN,                 // activate, low active
   input wire logic rasN,                 // row strobe, low active
   input wire logic casN,                 // column strobe, low active
   input wire logic weN,                  // write enable, low active
   input wire logic bg1,                  // bank group bit 1
   input wire logic bg0,                  // bank group bit 0
   input wire logic [1:0] ba,             // bank address
   input wire logic [ADDR_W-1:0] addr,    // address pins
   output logic [2:0] refMode,            // current refresh mode
   output logic tcrEnabled,               // temperature mode on
   output fgr_pkg::fgr_gran_e refGran,    // granularity in force
   output logic [fgr_pkg::REFI_W-1:0] refiCycles, // interval, cycles
   output logic refreshStart,             // pulse: refresh taken
   output logic refreshBusy,              // cycle time running
   output logic modeReservedErr,          // pulse: reserved mode
   output logic tcrConflictErr,           // level: tcr with non-1x
   output logic rateChangeErr,            // pulse: bad count on change
   output logic pairErr,                  // pulse: bad count between 1x
   output logic cmdDuringRfcErr           // pulse: command while busy
);
   typedef struct packed {
      logic [2:0] mode;
      logic temperature_controlled_refresh;
      fgr_pkg::fgr_gran_e gran;
      logic [fgr_pkg::REFI_W-1:0] refi;
      logic start;
      logic [1:0] cntRate;      // non-1x refreshes since rate change
      logic [1:0] cntPair;      // non-1x refreshes since last 1x
      logic resErr;
      logic tcrErr;
      logic rateErr;
      logic pairErr;
      logic cmdErr;
   } fgr_mode_s;

   fgr_mode_s s;
   fgr_mode_s next_s;
   fgr_rfc_if rfc ();

   logic isCmd;
   logic isRef;
   logic isMrs;
   logic refTake;
   logic [2:0] mrIdx;
   logic [2:0] newMode;
   fgr_pkg::fgr_gran_e selGran;

   initial begin
      if (ADDR_W < fgr_pkg::ADDR_MIN_W)
         $error("address too narrow for the mode field");
      if (fgr_pkg::REFI_BASE_CYC >= (1 << fgr_pkg::REFI_W))
         $error("interval count does not fit");
   end

   // rate class of a mode: fixed and dynamic forms share one class
   function automatic fgr_pkg::fgr_gran_e rate_class(logic [2:0] m);
      unique case (m)
         fgr_pkg::MODE_FIXED_2X, fgr_pkg::MODE_DYN_1X2X:
            return fgr_pkg::GRAN_2X;
         fgr_pkg::MODE_FIXED_4X, fgr_pkg::MODE_DYN_1X4X:
            return fgr_pkg::GRAN_4X;
         default: return fgr_pkg::GRAN_1X;
      endcase
   endfunction

   function automatic logic is_dynamic(logic [2:0] m);
      return m == fgr_pkg::MODE_DYN_1X2X || m == fgr_pkg::MODE_DYN_1X4X;
   endfunction

   function automatic logic [fgr_pkg::REFI_W-1:0] refi_of(
      fgr_pkg::fgr_gran_e g);
      logic [fgr_pkg::REFI_W-1:0] base;
      base = fgr_pkg::REFI_W'(fgr_pkg::REFI_BASE_CYC);
      // enum value is log2 of the rate: 1x, 2x, 4x shift by 0, 1, 2
      return base >> int'(g);
   endfunction

   // command decode
   always_comb begin
      isCmd = !csN;
      isRef = isCmd && {actN, rasN, casN, weN} == fgr_pkg::CMD_REFRESH;
      isMrs = isCmd && {actN, rasN, casN, weN} == fgr_pkg::CMD_MRS;
      mrIdx = {bg1, ba};
      newMode = addr[fgr_pkg::MODE_MSB:fgr_pkg::MODE_LSB];
      refTake = isRef && !rfc.busy;   // refresh ignored while busy
   end

   // granularity of an incoming refresh, by mode and selector bit
   always_comb begin
      unique case (s.mode)
         fgr_pkg::MODE_FIXED_2X: selGran = fgr_pkg::GRAN_2X;
         fgr_pkg::MODE_FIXED_4X: selGran = fgr_pkg::GRAN_4X;
         fgr_pkg::MODE_DYN_1X2X:
            selGran = bg0 ? fgr_pkg::GRAN_2X : fgr_pkg::GRAN_1X;
         fgr_pkg::MODE_DYN_1X4X:
            selGran = bg0 ? fgr_pkg::GRAN_4X : fgr_pkg::GRAN_1X;
         default: selGran = fgr_pkg::GRAN_1X;
      endcase
   end

   assign rfc.start = refTake;
   assign rfc.gran = selGran;

   // next state: refresh bookkeeping, mode register writes, checks
   always_comb begin
      logic [1:0] mask;
      mask = rate_class(s.mode) == fgr_pkg::GRAN_4X ?
             fgr_pkg::MASK_QUAD : fgr_pkg::MASK_EVEN;
      next_s = s;
      next_s.start = refTake;
      next_s.resErr = 1'b0;
      next_s.rateErr = 1'b0;
      next_s.pairErr = 1'b0;
      next_s.cmdErr = isCmd && rfc.busy;
      if (refTake) begin
         next_s.gran = selGran;
         next_s.refi = refi_of(selGran);
         if (selGran == fgr_pkg::GRAN_1X) begin
            // counts checked between 1x refreshes
            next_s.pairErr = is_dynamic(s.mode) &&
                             (s.cntPair & mask) != 2'h0;
            next_s.cntPair = 2'h0;
         end else begin
            next_s.cntRate = s.cntRate + 2'h1;
            next_s.cntPair = s.cntPair + 2'h1;
         end
      end else if (isMrs && mrIdx == fgr_pkg::MR_IDX_RATE) begin
         unique case (newMode)
            fgr_pkg::MODE_FIXED_1X, fgr_pkg::MODE_FIXED_2X,
            fgr_pkg::MODE_FIXED_4X, fgr_pkg::MODE_DYN_1X2X,
            fgr_pkg::MODE_DYN_1X4X: begin
               next_s.mode = newMode;
               if (rate_class(newMode) != rate_class(s.mode)) begin
                  // only a real rate change is checked
                  next_s.rateErr = (s.cntRate & mask) != 2'h0 &&
                     s.mode != fgr_pkg::MODE_FIXED_1X;
                  next_s.cntRate = 2'h0;
                  next_s.cntPair = 2'h0;
                  // dynamic modes start at 1x until a refresh picks
                  next_s.gran = is_dynamic(newMode) ?
                     fgr_pkg::GRAN_1X : rate_class(newMode);
                  next_s.refi = refi_of(next_s.gran);
               end
            end
            // reserved codes are refused, mode stays as it was
            default: next_s.resErr = 1'b1;
         endcase
      end else if (isMrs && mrIdx == fgr_pkg::MR_IDX_TCR) begin
         next_s.temperature_controlled_refresh = addr[fgr_pkg::TCR_BIT];
      end
      next_s.tcrErr = next_s.temperature_controlled_refresh &&
                      next_s.mode != fgr_pkg::MODE_FIXED_1X;
   end

   // state register; reset lands in fixed 1x at the base interval
   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
         s.mode <= fgr_pkg::MODE_FIXED_1X;
         s.gran <= fgr_pkg::GRAN_1X;
         s.refi <= fgr_pkg::REFI_W'(fgr_pkg::REFI_BASE_CYC);
      end else begin
         s <= next_s;
      end
   end

   fgr_rfc_timer #(.DENSITY(DENSITY)) u_timer (
      .clk(clk),
      .srst(srst),
      .rfc(rfc)
   );

   // outputs straight from the state flops
   assign refMode = s.mode;
   assign tcrEnabled = s.temperature_controlled_refresh;
   assign refGran = s.gran;
   assign refiCycles = s.refi;
   assign refreshStart = s.start;
   assign refreshBusy = rfc.busy;
   assign modeReservedErr = s.resErr;
   assign tcrConflictErr = s.tcrErr;
   assign rateChangeErr = s.rateErr;
   assign pairErr = s.pairErr;
   assign cmdDuringRfcErr = s.cmdErr;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_tcr_write;
      isMrs && mrIdx == fgr_pkg::MR_IDX_TCR |=>
         tcrEnabled == $past(addr[fgr_pkg::TCR_BIT]);
   endproperty
   a_tcr_write: assert property (p_tcr_write)
      else $error("temperature mode bit not taken");

   property p_reserved;
      isMrs && mrIdx == fgr_pkg::MR_IDX_RATE && !refTake &&
      newMode inside {3'h3, 3'h4, 3'h7} |=>
         modeReservedErr && refMode == $past(refMode);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved mode not refused");

   property p_dyn_pick;
      refTake && s.mode == fgr_pkg::MODE_DYN_1X4X |=>
         refGran == ($past(bg0) ? fgr_pkg::GRAN_4X : fgr_pkg::GRAN_1X);
   endproperty
   a_dyn_pick: assert property (p_dyn_pick)
      else $error("dynamic granularity wrong");

   property p_fixed_pick;
      refTake && s.mode == fgr_pkg::MODE_FIXED_1X |=>
         refGran == fgr_pkg::GRAN_1X ##1 refreshBusy;
   endproperty
   a_fixed_pick: assert property (p_fixed_pick)
      else $error("fixed mode granularity wrong");

   property p_interval;
      refreshStart && refGran == fgr_pkg::GRAN_2X |->
         refiCycles == fgr_pkg::REFI_W'(fgr_pkg::REFI_BASE_CYC / 2);
   endproperty
   a_interval: assert property (p_interval)
      else $error("2x interval wrong");

   property p_busy_cmd;
      isCmd && refreshBusy |=> cmdDuringRfcErr;
   endproperty
   a_busy_cmd: assert property (p_busy_cmd)
      else $error("command during refresh not flagged");

   property p_same_rate;
      isMrs && mrIdx == fgr_pkg::MR_IDX_RATE && !refTake &&
      newMode == fgr_pkg::MODE_DYN_1X2X &&
      s.mode == fgr_pkg::MODE_FIXED_2X |=> !rateChangeErr;
   endproperty
   a_same_rate: assert property (p_same_rate)
      else $error("same-rate switch flagged");

   property p_odd_change;
      isMrs && mrIdx == fgr_pkg::MR_IDX_RATE && !refTake &&
      newMode == fgr_pkg::MODE_FIXED_1X &&
      s.mode == fgr_pkg::MODE_FIXED_2X && s.cntRate[0] |=> rateChangeErr;
   endproperty
   a_odd_change: assert property (p_odd_change)
      else $error("odd 2x count on change not flagged");

   c_dyn_4x: cover property (refreshStart && refGran == fgr_pkg::GRAN_4X);
   c_rate_chg: cover property (rateChangeErr);
   c_pair: cover property (pairErr);
endmodule // fgr_refresh_mode

// *** common/fgr_pkg.sv ***
// constants and types for the refresh granularity mode block
// assumes a single 250 MHz command clock and the density chosen at build
package fgr_pkg;

   // refresh granularity of one refresh command
   typedef enum logic [1:0] {GRAN_1X, GRAN_2X, GRAN_4X} fgr_gran_e;

   localparam int CLK_MHZ = 250;               // command clock rate
   localparam int REFI_BASE_US_X10 = 78;       // base interval, 7.8 us
   // longest time, so the count rounds down
   localparam int REFI_BASE_CYC = REFI_BASE_US_X10 * CLK_MHZ / 10;
   localparam int REFI_W = 12;

   // refresh cycle time in ns, per granularity then per density
   localparam int RFC_NS [3][4] = '{
      '{160, 260, 350, 550},
      '{110, 160, 260, 350},
      '{90, 110, 160, 260}};
   localparam int NS_PER_US = 1000;
   localparam int RFC_CNT_W = 8;
   localparam int DENSITY_COUNT = 4;           // 2, 4, 8, 16 Gb

   // least time, so the count rounds up
   function automatic int rfc_cycles(int gran, int dens);
      return (RFC_NS[gran][dens] * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
   endfunction

   // refresh mode field encodings
   localparam logic [2:0] MODE_FIXED_1X = 3'h0;
   localparam logic [2:0] MODE_FIXED_2X = 3'h1;
   localparam logic [2:0] MODE_FIXED_4X = 3'h2;
   localparam logic [2:0] MODE_DYN_1X2X = 3'h5;
   localparam logic [2:0] MODE_DYN_1X4X = 3'h6;

   // mode register selection and field positions
   localparam logic [2:0] MR_IDX_RATE = 3'h3;
   localparam logic [2:0] MR_IDX_TCR = 3'h4;
   localparam int MODE_LSB = 6;
   localparam int MODE_MSB = 8;
   localparam int TCR_BIT = 3;
   localparam int ADDR_MIN_W = MODE_MSB + 1;

   // {act, ras, cas, we} with chip select low
   localparam logic [3:0] CMD_REFRESH = 4'h9;
   localparam logic [3:0] CMD_MRS = 4'h8;

   // refresh count masks checked before a rate change
   localparam logic [1:0] MASK_EVEN = 2'h1;
   localparam logic [1:0] MASK_QUAD = 2'h3;

endpackage

// *** common/fgr_rfc_if.sv ***
// link between the mode logic and the refresh cycle timer
// assumes both ends share one clock
`timescale 1ns/1ps
interface fgr_rfc_if;
   logic start;                 // refresh taken this cycle
   fgr_pkg::fgr_gran_e gran;    // granularity of that refresh
   logic busy;                  // refresh cycle time still running

   modport ctrl (output start, output gran, input busy);
   modport timer (input start, input gran, output busy);
endinterface

// *** logic/fgr_rfc_timer.sv ***
// refresh cycle timer: busy from the cycle after a refresh until its
// cycle time has run; assumes start is only raised while idle
`timescale 1ns/1ps
module fgr_rfc_timer #(
   parameter int DENSITY = 1    // 0..3 for 2, 4, 8, 16 Gb
) (
   input wire logic clk,        // command clock
   input wire logic srst,       // synchronous reset, active high
   fgr_rfc_if.timer rfc         // start and busy handshake
);
   typedef struct packed {
      logic busy;
      logic [fgr_pkg::RFC_CNT_W-1:0] cnt;
   } fgr_tmr_s;

   fgr_tmr_s s;
   fgr_tmr_s next_s;
   logic [fgr_pkg::RFC_CNT_W-1:0] loadVal;

   initial begin
      if (DENSITY < 0 || DENSITY >= fgr_pkg::DENSITY_COUNT)
         $error("density index out of range");
      if (fgr_pkg::rfc_cycles(2, 0) < 2 ||
          fgr_pkg::rfc_cycles(0, 3) >= (1 << fgr_pkg::RFC_CNT_W))
         $error("refresh cycle count does not fit the counter");
   end

   // each refresh loads the cycle time of its own granularity
   always_comb begin
      loadVal = fgr_pkg::RFC_CNT_W'(
         fgr_pkg::rfc_cycles(int'(rfc.gran), DENSITY) - 1);
      next_s = s;
      if (s.busy) begin
         if (s.cnt == fgr_pkg::RFC_CNT_W'(1)) begin
            next_s.busy = 1'b0;
            next_s.cnt = '0;
         end else begin
            next_s.cnt = s.cnt - fgr_pkg::RFC_CNT_W'(1);
         end
      end else if (rfc.start) begin
         next_s.busy = 1'b1;            // timed from issue
         next_s.cnt = loadVal;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (srst)
         s <= '0;
      else
         s <= next_s;
   end

   assign rfc.busy = s.busy;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_rfc_load;
      rfc.start && !s.busy |=> s.busy && s.cnt == $past(loadVal);
   endproperty
   a_rfc_load: assert property (p_rfc_load)
      else $error("refresh cycle time not loaded");

   property p_rfc_release;
      $fell(s.busy) |-> $past(s.cnt) == fgr_pkg::RFC_CNT_W'(1);
   endproperty
   a_rfc_release: assert property (p_rfc_release)
      else $error("refresh cycle ended early");

   c_rfc_full: cover property (rfc.start ##1 s.busy [*8] ##[1:200] !s.busy);
endmodule // fgr_rfc_timer

// *** testbench/fgr_ctrl_model.sv ***
// memory controller model: drives MRS and REFRESH on the command pins
// assumes one bench process calls its tasks, one at a time
`timescale 1ns/1ps
module fgr_ctrl_model #(
   parameter int ADDR_W = 18     // address pins carried
) (
   input wire logic clk,         // command clock
   input wire logic rfcBusy,     // device cycle time running
   output logic csN,             // chip select, low active
   output logic actN,            // activate, low active
   output logic rasN,            // row strobe, low active
   output logic casN,            // column strobe, low active
   output logic weN,             // write enable, low active
   output logic bg1,             // bank group bit 1
   output logic bg0,             // bank group bit 0
   output logic [1:0] ba,        // bank address
   output logic [ADDR_W-1:0] addr // address pins
);
   // deselected at time zero
   initial begin
      csN = 1'b1;
      {actN, rasN, casN, weN} = 4'hf;
      {bg1, bg0, ba} = 4'h0;
      addr = '0;
   end

   // released lines flip so a stale value never looks valid
   task automatic release_bus();
      csN <= 1'b1;
      {actN, rasN, casN, weN} <= ~{actN, rasN, casN, weN};
      {bg1, bg0, ba} <= ~{bg1, bg0, ba};
      addr <= ~addr;
   endtask

   // one command, held for one cycle, released at the taking edge
   task automatic issue(input logic [3:0] code, input logic [3:0] sel,
         input logic [ADDR_W-1:0] a);
      @(posedge clk);
      csN <= 1'b0;
      {actN, rasN, casN, weN} <= code;
      {bg1, bg0, ba} <= sel;
      addr <= a;
      @(posedge clk);
      release_bus();
   endtask

   // only deselects until the running cycle time has ended
   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (rfcBusy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // mode register write, register index on bank group 1 and bank
   task automatic mrs(input logic [2:0] idx, input logic [ADDR_W-1:0] a);
      wait_idle();
      issue(fgr_pkg::CMD_MRS, {idx[2], 1'b0, idx[1:0]}, a);
   endtask

   // refresh; waits out the cycle time unless told to break it
   task automatic refresh(input logic sel, input logic early);
      if (!early)
         wait_idle();
      // selector on bank group 0, other pins are don't-care
      issue(fgr_pkg::CMD_REFRESH, {~sel, sel, ~sel, sel}, ~addr);
   endtask
endmodule // fgr_ctrl_model

// *** testbench/fgr_refresh_mode_tb_top.sv ***
// self-checking bench for the refresh rate mode logic
// assumes density 1 (4 Gb) and the controller model beside it
`timescale 1ns/1ps
module fgr_refresh_mode_tb_top;
   localparam int LIMIT = 20000; // just over a thousand cycles expected
   localparam int RFC_NS [3] = '{260, 160, 110};
   logic clk, srst, csN, actN, rasN, casN, weN, bg1, bg0;
   logic [1:0] ba;
   logic [17:0] addr;
   logic [2:0] refMode;
   logic tcrEnabled, refreshStart, refreshBusy, modeReservedErr;
   logic tcrConflictErr, rateChangeErr, pairErr, cmdDuringRfcErr;
   fgr_pkg::fgr_gran_e refGran;
   logic [fgr_pkg::REFI_W-1:0] refiCycles;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;

   fgr_refresh_mode #(.DENSITY(1), .ADDR_W(18)) dut (.clk(clk),
      .srst(srst), .csN(csN), .actN(actN), .rasN(rasN), .casN(casN),
      .weN(weN), .bg1(bg1), .bg0(bg0), .ba(ba), .addr(addr),
      .refMode(refMode), .tcrEnabled(tcrEnabled), .refGran(refGran),
      .refiCycles(refiCycles), .refreshStart(refreshStart),
      .refreshBusy(refreshBusy), .modeReservedErr(modeReservedErr),
      .tcrConflictErr(tcrConflictErr), .rateChangeErr(rateChangeErr),
      .pairErr(pairErr), .cmdDuringRfcErr(cmdDuringRfcErr));
   fgr_ctrl_model #(.ADDR_W(18)) ctrl (.clk(clk), .rfcBusy(refreshBusy),
      .csN(csN), .actN(actN), .rasN(rasN), .casN(casN), .weN(weN),
      .bg1(bg1), .bg0(bg0), .ba(ba), .addr(addr));

   // 250 MHz clock
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // mode writes and refreshes; outputs sampled the cycle after
   task automatic set_mode(input logic [2:0] m);
      logic [17:0] a;
      a = '0;
      a[fgr_pkg::MODE_MSB:fgr_pkg::MODE_LSB] = m;
      ctrl.mrs(fgr_pkg::MR_IDX_RATE, a);
      #1;
   endtask

   task automatic set_tcr(input logic t);
      logic [17:0] a;
      a = '0;
      a[fgr_pkg::TCR_BIT] = t;
      ctrl.mrs(fgr_pkg::MR_IDX_TCR, a);
      #1;
   endtask

   task automatic ref1(input logic sel);
      ctrl.refresh(sel, 1'b0);
      #1;
   endtask

   task automatic chk_gran(input int g);
      chk(12'(refGran), 12'(g));
      chk(refiCycles, 12'(fgr_pkg::REFI_BASE_CYC >> g));
   endtask

   task automatic t_reset();
      chk(12'(refMode), 12'h000);
      chk(12'(refGran), 12'h000);
      chk(refiCycles, 12'(fgr_pkg::REFI_BASE_CYC));
      chk({8'h00, tcrEnabled, refreshBusy, tcrConflictErr, pairErr},
         12'h000);
   endtask

   // every legal code, then cycle time per granularity
   task automatic t_modes();
      int n, cnt;
      logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
      int gr [5] = '{1, 2, 0, 0, 0};
      for (int i = 0; i < 5; i++) begin
         set_mode(codes[i]);
         chk(12'(refMode), 12'(codes[i]));
         chk_gran(gr[i]);
      end
      for (int g = 0; g < 3; g++) begin
         set_mode(3'(g));
         chk(12'(rateChangeErr), 12'h000);
         for (int r = 0; r < (1 << g); r++)
            ref1(1'b0);
         chk(12'(refreshStart), 12'h001);
         chk_gran(g);
         n = (RFC_NS[g] * 250 + 999) / 1000;
         cnt = 0;
         while (refreshBusy === 1'b1 && cnt < 200) begin
            cnt++;
            @(posedge clk);
            #1;
         end
         chk(12'(cnt), 12'(n - 1));
      end
      set_mode(3'h0);
      chk(12'(rateChangeErr), 12'h000);
   endtask

   // selector use and counts between 1x refreshes
   task automatic t_dyn();
      set_mode(3'h5);
      ref1(1'b1);
      chk_gran(1);
      ref1(1'b1);
      ref1(1'b0);
      chk_gran(0);
      chk(12'(pairErr), 12'h000);
      ref1(1'b1);
      ref1(1'b0);
      chk(12'(pairErr), 12'h001);
      ref1(1'b1);
      set_mode(3'h6);
      chk(12'(rateChangeErr), 12'h000);
      ref1(1'b1);
      chk_gran(2);
      ref1(1'b0);
      chk(12'(pairErr), 12'h001);
      for (int i = 0; i < 4; i++)
         ref1(1'b1);
      ref1(1'b0);
      chk(12'(pairErr), 12'h000);
      set_mode(3'h0);
      chk(12'(rateChangeErr), 12'h001);
      ref1(1'b1);
      chk_gran(0);
   endtask

   task automatic t_same_rate();
      set_mode(3'h1);
      ref1(1'b1);
      set_mode(3'h5);
      chk(12'(rateChangeErr), 12'h000);
      chk_gran(1);
      set_mode(3'h0);
      chk(12'(rateChangeErr), 12'h001);
      // odd 2x count when leaving the fixed 2x mode
      set_mode(3'h1);
      ref1(1'b0);
      set_mode(3'h0);
      chk(12'(rateChangeErr), 12'h001);
   endtask

   task automatic t_reserved();
      logic [2:0] codes [3] = '{3'h3, 3'h4, 3'h7};
      for (int i = 0; i < 3; i++) begin
         set_mode(codes[i]);
         chk(12'(modeReservedErr), 12'h001);
         chk(12'(refMode), 12'h000);
      end
   endtask

   task automatic t_tcr();
      set_tcr(1'b1);
      chk(12'({tcrEnabled, tcrConflictErr}), 12'h002);
      set_mode(3'h1);
      chk(12'(tcrConflictErr), 12'h001);
      set_mode(3'h0);
      chk(12'(tcrConflictErr), 12'h000);
      set_tcr(1'b0);
      chk(12'(tcrEnabled), 12'h000);
   endtask

   // a refresh inside the cycle time is refused and flagged
   task automatic t_busy();
      ref1(1'b0);
      ctrl.refresh(1'b0, 1'b1);
      #1;
      chk(12'({cmdDuringRfcErr, refreshStart}), 12'h002);
   endtask

   // main sequence
   initial begin
      srst = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_modes();
      t_dyn();
      t_same_rate();
      t_reserved();
      t_tcr();
      t_busy();
      end_sim();
   end
endmodule // fgr_refresh_mode_tb_top
